// ===== src/sbd_decoder.sv
// Instruction decoder and execution unit behind an AHB-Lite register port
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module sbd_decoder
	import sbd_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp
);
	// Input registers written by software
	logic [15:0] instr_q, opa_q, opb_q, pc_q, sp_q, sr_q, tos0_q, tos1_q, ctrl_q;
	// Results latched on each execute command
	logic [15:0] res_q, npc_q, nsp_q, nsr_q, maddr_q, mdata_q;
	logic [15:0] info_q;
	logic        wr_pend_q;
	logic [11:0] waddr_q;
	logic        rd_pend_q;
	logic [11:0] raddr_q;

	sbd_fields_s f;
	sbd_field_split u_split (
		.instr  (instr_q),
		.fields (f)
	);

	// Byte results live in the low byte with the high byte cleared
	function automatic logic [15:0] fit(input logic [15:0] v, input logic b);
		fit = b ? {8'h00, v[7:0]} : v;
	endfunction

	function automatic logic msb(input logic [15:0] v, input logic b);
		msb = b ? v[7] : v[15];
	endfunction

	function automatic logic zero(input logic [15:0] v, input logic b);
		zero = b ? (v[7:0] == 8'h00) : (v == 16'h0000);
	endfunction

	// Decimal add across four digits, two in byte mode; carry out taken from the chosen width
	function automatic logic [16:0] bcd_add(input logic [15:0] a, input logic [15:0] d,
		input logic ci, input logic b);
		logic [15:0] r;
		logic        c;
		logic [4:0]  s;
		r = 16'h0000;
		c = ci;
		for (int i = 0; i < 4; i++) begin
			s = {1'b0, a[i*4 +: 4]} + {1'b0, d[i*4 +: 4]} + {4'h0, c};
			if (s > 5'd9) begin
				s = s + 5'd6;
			end
			r[i*4 +: 4] = s[3:0];
			c = s[4];
			if (b && i == 1) begin
				bcd_add = {c, 8'h00, r[7:0]};
				return bcd_add;
			end
		end
		bcd_add = {c, r};
	endfunction

	wire         bw      = f.byte_select;
	wire [15:0]  src     = fit(opa_q, bw);
	wire [15:0]  dst     = fit(opb_q, bw);
	wire         cin     = sr_q[SR_C];
	wire         nin     = sr_q[SR_N];
	wire         vin     = sr_q[SR_V];
	wire         zin     = sr_q[SR_Z];

	// Adder shared by sum, subtract and compare
	wire         is_sub  = f.op1 == OP_MINUS_WITH_CARRY || f.op1 == OP_SUB || f.op1 == OP_CMP;
	wire [15:0]  add_b   = is_sub ? fit(~opa_q, bw) : src;
	wire         add_ci  = (f.op1 == OP_SUB || f.op1 == OP_CMP) ? 1'b1 :
		(f.op1 == OP_SUM_WITH_CARRY_IN || f.op1 == OP_MINUS_WITH_CARRY) ? cin : 1'b0;
	wire [16:0]  add_sum = {1'b0, dst} + {1'b0, add_b} + {16'h0000, add_ci};
	wire [15:0]  add_r   = fit(add_sum[15:0], bw);
	wire         add_c   = bw ? add_sum[8] : add_sum[16];
	wire         add_v   = (msb(dst, bw) == msb(add_b, bw)) && (msb(add_r, bw) != msb(dst, bw));
	wire [16:0]  dec     = bcd_add(src, dst, cin, bw);

	// Single-operand data paths
	wire [15:0]  rrc_r   = bw ? {8'h00, cin, opb_q[7:1]} : {cin, opb_q[15:1]};
	wire [15:0]  rra_r   = bw ? {8'h00, opb_q[7], opb_q[7:1]} : {opb_q[15], opb_q[15:1]};
	wire [15:0]  swp_r   = {opb_q[7:0], opb_q[15:8]};
	wire [15:0]  sxt_r   = {{8{opb_q[7]}}, opb_q[7:0]};
	wire [15:0]  sp_dn   = sp_q - STEP;
	wire [15:0]  sp_up1  = sp_q + STEP;
	wire [15:0]  sp_up2  = sp_up1 + STEP;
	wire [15:0]  ret_pc  = pc_q + STEP;

	// Jump condition and target
	wire [15:0]  j_off   = {{5{f.offset[9]}}, f.offset, 1'b0};
	wire [15:0]  j_tgt   = pc_q + STEP + j_off;
	logic        j_take;
	always_comb begin
		case (sbd_cond_e'(f.cond))
			J_Z:      j_take = zin;
			J_NZ:     j_take = !zin;
			J_C:      j_take = cin;
			J_NC:     j_take = !cin;
			J_N:      j_take = nin;
			J_GE:     j_take = (nin ^ vin) == 1'b0;
			J_L:      j_take = (nin ^ vin) == 1'b1;
			default:  j_take = 1'b1;
		endcase
	end

	// Execution: result, flags, stack and program counter
	logic [15:0] x_res, x_pc, x_sp, x_sr, x_maddr, x_mdata;
	logic        x_wr, x_mem, x_upd;
	logic        x_v, x_n, x_z, x_c;
	always_comb begin
		x_res   = 16'h0000;
		x_pc    = ret_pc;
		x_sp    = sp_q;
		x_sr    = sr_q;
		x_maddr = 16'h0000;
		x_mdata = 16'h0000;
		x_wr    = 1'b0;
		x_mem   = 1'b0;
		x_upd   = 1'b0;
		x_v     = 1'b0;
		x_n     = 1'b0;
		x_z     = 1'b0;
		x_c     = 1'b0;
		case (f.fmt)
			FMT_DUAL: begin
				x_upd = 1'b1;
				x_wr  = 1'b1;
				case (sbd_op1_e'(f.op1))
					OP_COPY: begin
						x_res = src;
						x_upd = 1'b0;
					end
					OP_ADD, OP_SUM_WITH_CARRY_IN, OP_SUB, OP_MINUS_WITH_CARRY, OP_CMP: begin
						x_res = add_r;
						x_c   = add_c;
						x_v   = add_v;
						x_wr  = f.op1 != OP_CMP;
					end
					OP_DECIMAL_SUM_OP: begin
						x_res = dec[15:0];
						x_c   = dec[16];
					end
					OP_BIT, OP_AND: begin
						x_res = src & dst;
						x_c   = !zero(src & dst, bw);
						x_wr  = f.op1 == OP_AND;
					end
					OP_BIC: begin
						x_res = fit(~opa_q, bw) & dst;
						x_upd = 1'b0;
					end
					OP_BIS: begin
						x_res = src | dst;
						x_upd = 1'b0;
					end
					default: begin
						x_res = src ^ dst;
						x_c   = !zero(src ^ dst, bw);
						x_v   = msb(src, bw) && msb(dst, bw);
					end
				endcase
			end
			FMT_SINGLE: begin
				case (sbd_op2_e'(f.op2))
					F2_RRC: begin
						x_res = rrc_r;
						x_wr  = 1'b1;
						x_upd = 1'b1;
						x_c   = opb_q[0];
					end
					F2_RRA: begin
						x_res = rra_r;
						x_wr  = 1'b1;
						x_upd = 1'b1;
						x_c   = opb_q[0];
					end
					F2_BYTE_SWAP_OP: begin
						x_res = swp_r;
						x_wr  = 1'b1;
					end
					F2_SXT: begin
						x_res = sxt_r;
						x_wr  = 1'b1;
						x_upd = 1'b1;
						x_c   = sxt_r != 16'h0000;
					end
					F2_PUSH: begin
						x_sp    = sp_dn;
						x_maddr = sp_dn;
						x_mdata = fit(opb_q, bw);
						x_mem   = 1'b1;
					end
					F2_CALL: begin
						x_sp    = sp_dn;
						x_maddr = sp_dn;
						x_mdata = ret_pc;
						x_mem   = 1'b1;
						x_pc    = opb_q;
					end
					default: begin
						x_sr = tos0_q;
						x_pc = tos1_q;
						x_sp = sp_up2;
					end
				endcase
			end
			FMT_JUMP: begin
				x_pc = j_take ? j_tgt : ret_pc;
			end
			default: begin
				x_pc = pc_q;
			end
		endcase
		if (x_upd) begin
			x_n  = msb(x_res, bw);
			x_z  = zero(x_res, bw);
			x_sr = sr_q;
			x_sr[SR_V] = x_v;
			x_sr[SR_N] = x_n;
			x_sr[SR_Z] = x_z;
			x_sr[SR_C] = x_c;
		end
	end

	// AHB-Lite slave: writes land in the data phase, reads answer with no wait
	wire         take     = hsel && hready && htrans[1];
	wire         bad_size = hsize != 3'h2;
	wire         go       = wr_pend_q && waddr_q == OFF_CTRL && hwdata[0];
	wire [15:0]  wd       = hwdata[15:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			waddr_q   <= 12'h000;
			raddr_q   <= 12'h000;
		end else begin
			wr_pend_q <= take && hwrite && !bad_size;
			rd_pend_q <= take && !hwrite;
			waddr_q   <= haddr;
			raddr_q   <= haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			instr_q <= 16'h0000;
			opa_q   <= 16'h0000;
			opb_q   <= 16'h0000;
			pc_q    <= 16'h0000;
			sp_q    <= 16'h0000;
			sr_q    <= 16'h0000;
			tos0_q  <= 16'h0000;
			tos1_q  <= 16'h0000;
			ctrl_q  <= RESET_CTRL;
		end else if (wr_pend_q) begin
			if (waddr_q == OFF_INSTR) instr_q <= wd;
			else if (waddr_q == OFF_OPA) opa_q <= wd;
			else if (waddr_q == OFF_OPB) opb_q <= wd;
			else if (waddr_q == OFF_PC) pc_q <= wd;
			else if (waddr_q == OFF_SP) sp_q <= wd;
			else if (waddr_q == OFF_SR) sr_q <= wd;
			else if (waddr_q == OFF_TOS0) tos0_q <= wd;
			else if (waddr_q == OFF_TOS1) tos1_q <= wd;
			else if (waddr_q == OFF_CTRL) ctrl_q <= {wd[15:1], 1'b0};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res_q   <= 16'h0000;
			npc_q   <= 16'h0000;
			nsp_q   <= 16'h0000;
			nsr_q   <= 16'h0000;
			maddr_q <= 16'h0000;
			mdata_q <= 16'h0000;
			info_q  <= 16'h0000;
		end else if (go) begin
			res_q   <= x_res;
			npc_q   <= x_pc;
			nsp_q   <= x_sp;
			nsr_q   <= x_sr;
			maddr_q <= x_maddr;
			mdata_q <= x_mdata;
			info_q  <= {9'h000, f.fmt == FMT_JUMP && j_take, x_mem, x_wr,
				f.fmt == FMT_ILLEGAL, bw, f.fmt};
		end
	end

	// Read data is driven combinationally from the registers in the data phase
	wire [15:0] rd_mux =
		(raddr_q == OFF_INSTR)  ? instr_q :
		(raddr_q == OFF_OPA)    ? opa_q   :
		(raddr_q == OFF_OPB)    ? opb_q   :
		(raddr_q == OFF_PC)     ? pc_q    :
		(raddr_q == OFF_SP)     ? sp_q    :
		(raddr_q == OFF_SR)     ? sr_q    :
		(raddr_q == OFF_TOS0)   ? tos0_q  :
		(raddr_q == OFF_TOS1)   ? tos1_q  :
		(raddr_q == OFF_CTRL)   ? ctrl_q  :
		(raddr_q == OFF_RESULT) ? res_q   :
		(raddr_q == OFF_NPC)    ? npc_q   :
		(raddr_q == OFF_NSP)    ? nsp_q   :
		(raddr_q == OFF_NSR)    ? nsr_q   :
		(raddr_q == OFF_MEM)    ? maddr_q :
		(raddr_q == OFF_INFO)   ? info_q  :
		(raddr_q == OFF_DECODE) ? {f.src_reg, f.dst_mode, f.byte_select,
			f.src_mode_bits, f.dst_reg, 4'h0} : 16'h0000;

	assign hrdata    = rd_pend_q ? {16'h0000, rd_mux} : 32'h00000000;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Stack data for push and call is latched but never read back; OFF_MEM shows only the stack address
	wire unused_ok = ^mdata_q;
endmodule

// ===== src/sbd_pkg.sv
// Package with instruction fields, opcodes and flag positions for the decoder
package sbd_pkg;
	localparam int          WORD_W       = 16;
	// Register bus map
	localparam logic [11:0] OFF_INSTR    = 12'h000;
	localparam logic [11:0] OFF_OPA      = 12'h004;
	localparam logic [11:0] OFF_OPB      = 12'h008;
	localparam logic [11:0] OFF_PC       = 12'h00C;
	localparam logic [11:0] OFF_SP       = 12'h010;
	localparam logic [11:0] OFF_SR       = 12'h014;
	localparam logic [11:0] OFF_TOS0     = 12'h018;
	localparam logic [11:0] OFF_TOS1     = 12'h01C;
	localparam logic [11:0] OFF_CTRL     = 12'h020;
	localparam logic [11:0] OFF_RESULT   = 12'h024;
	localparam logic [11:0] OFF_NPC      = 12'h028;
	localparam logic [11:0] OFF_NSP      = 12'h02C;
	localparam logic [11:0] OFF_NSR      = 12'h030;
	localparam logic [11:0] OFF_MEM      = 12'h034;
	localparam logic [11:0] OFF_INFO     = 12'h038;
	localparam logic [11:0] OFF_DECODE   = 12'h03C;
	// Status register flag positions
	localparam int          SR_C         = 0;
	localparam int          SR_Z         = 1;
	localparam int          SR_N         = 2;
	localparam int          SR_V         = 8;
	// Field positions
	localparam int          F1_OP_LSB    = 12;
	localparam int          F1_SRC_LSB   = 8;
	localparam int          F1_AD_BIT    = 7;
	localparam int          BW_BIT       = 6;
	localparam int          MODE_LSB     = 4;
	localparam int          F2_OP_LSB    = 7;
	localparam int          JMP_COND_LSB = 10;
	localparam int          JMP_OFF_W    = 10;
	localparam logic [2:0]  JMP_PREFIX   = 3'h1;
	localparam logic [5:0]  F2_PREFIX    = 6'h04;
	localparam logic [15:0] STEP         = 16'h0002;
	localparam logic [15:0] RESET_CTRL   = 16'h0000;

	typedef enum logic [3:0] {
		OP_F2 = 4'h1, OP_JA = 4'h2, OP_JB = 4'h3, OP_COPY = 4'h4, OP_ADD = 4'h5,
		OP_SUM_WITH_CARRY_IN = 4'h6, OP_MINUS_WITH_CARRY = 4'h7, OP_SUB = 4'h8, OP_CMP = 4'h9, OP_DECIMAL_SUM_OP = 4'hA,
		OP_BIT = 4'hB, OP_BIC = 4'hC, OP_BIS = 4'hD, OP_XOR = 4'hE, OP_AND = 4'hF
	} sbd_op1_e;

	typedef enum logic [2:0] {
		F2_RRC = 3'h0, F2_BYTE_SWAP_OP = 3'h1, F2_RRA = 3'h2, F2_SXT = 3'h3,
		F2_PUSH = 3'h4, F2_CALL = 3'h5, F2_INTERRUPT_RETURN_OP = 3'h6, F2_BAD = 3'h7
	} sbd_op2_e;

	typedef enum logic [2:0] {
		J_NZ = 3'h0, J_Z = 3'h1, J_NC = 3'h2, J_C = 3'h3,
		J_N = 3'h4, J_GE = 3'h5, J_L = 3'h6, J_ALWAYS = 3'h7
	} sbd_cond_e;

	typedef enum logic [1:0] {
		FMT_DUAL = 2'h0, FMT_SINGLE = 2'h1, FMT_JUMP = 2'h2, FMT_ILLEGAL = 2'h3
	} sbd_fmt_e;

	typedef struct packed {
		sbd_fmt_e   fmt;
		logic [3:0] op1;
		logic [2:0] op2;
		logic [2:0] cond;
		logic [3:0] src_reg;
		logic       dst_mode;
		logic       byte_select;
		logic [1:0] src_mode_bits;
		logic [3:0] dst_reg;
		logic [9:0] offset;
	} sbd_fields_s;
endpackage

// ===== src/sbd_field_split.sv
// Splits an instruction word into its format and fields
`timescale 1ns/100ps
module sbd_field_split
	import sbd_pkg::*;
(
	input  wire logic [15:0] instr,
	output sbd_fields_s      fields
);
	wire         is_jump   = instr[15:13] == JMP_PREFIX;
	wire         is_single = instr[15:10] == F2_PREFIX;
	wire         is_dual   = instr[15:14] != 2'b00;
	wire [2:0]   op2       = instr[F2_OP_LSB +: 3];
	wire         f2_bad    = (op2 == F2_BAD) || (instr[BW_BIT] && (op2 == F2_BYTE_SWAP_OP ||
		op2 == F2_SXT || op2 == F2_CALL || op2 == F2_INTERRUPT_RETURN_OP));
	sbd_fmt_e    fmt;

	assign fmt = is_jump ? FMT_JUMP : (is_single && !f2_bad) ? FMT_SINGLE :
		is_dual ? FMT_DUAL : FMT_ILLEGAL;
	assign fields.fmt           = fmt;
	assign fields.op1           = instr[F1_OP_LSB +: 4];
	assign fields.op2           = op2;
	assign fields.cond          = instr[JMP_COND_LSB +: 3];
	assign fields.src_reg       = instr[F1_SRC_LSB +: 4];
	assign fields.dst_mode      = instr[F1_AD_BIT];
	assign fields.byte_select   = instr[BW_BIT];
	assign fields.src_mode_bits = instr[MODE_LSB +: 2];
	assign fields.dst_reg       = instr[3:0];
	assign fields.offset        = instr[JMP_OFF_W-1:0];
endmodule

// ===== verif/sbd_decoder_monitor.sv
// Checker that watches the decoder's register port
`timescale 1ns/100ps
module sbd_decoder_monitor
	import sbd_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp
);
	logic        dp_q, wr_q, rd_q, ev_q;
	logic [11:0] da_q;
	logic [15:0] in_q, pc_q, sp_q, sr_q, ei_q, ep_q, es_q, ef_q;
	wire logic        wdone = dp_q & wr_q & hready;
	wire logic [15:0] wd    = hwdata[15:0];
	wire logic        rv    = dp_q & rd_q & ev_q;
	wire logic [15:0] rdv   = hrdata[15:0];
	wire logic        jump_always   = ei_q[15:13] == JMP_PREFIX;
	wire logic [3:0]  o1    = ei_q[15:12];
	wire logic [2:0]  o2    = ei_q[9:7];
	wire logic [2:0]  f     = {ef_q[SR_N], ef_q[SR_C], ef_q[SR_Z]};
	wire logic        nxv   = ef_q[SR_N] ^ ef_q[SR_V];
	wire logic [7:0]  tt    = {1'b1, nxv, !nxv, f[2], f[1], !f[1], f[0], !f[0]};
	wire logic        tk    = tt[ei_q[12:10]];
	wire logic [15:0] tgt   = ep_q + STEP + {{5{ei_q[9]}}, ei_q[9:0], 1'b0};

	// Data-phase tracking of the bus
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{dp_q, wr_q, rd_q, da_q} <= 15'h0000;
		end else if (hready) begin
			{dp_q, wr_q, rd_q, da_q} <= {hsel & htrans[1], hwrite & (hsize == 3'h2), !hwrite, haddr};
		end
	end
	// Shadow of instruction, PC, SP and SR registers, frozen at each execute
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{in_q, pc_q, sp_q, sr_q, ei_q, ep_q, es_q, ef_q, ev_q} <= 129'h0;
		end else if (wdone) begin
			if (da_q == OFF_INSTR) in_q <= wd;
			if (da_q == OFF_PC) pc_q <= wd;
			if (da_q == OFF_SP) sp_q <= wd;
			if (da_q == OFF_SR) sr_q <= wd;
			if (da_q == OFF_CTRL && wd[0]) {ei_q, ep_q, es_q, ef_q, ev_q} <= {in_q, pc_q, sp_q, sr_q, 1'b1};
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_UPPER_ZERO: assert property (dp_q && rd_q |-> hrdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	AST_JUMP_TARGET: assert property (rv && da_q == OFF_NPC && jump_always && tk |-> rdv == tgt)
		else $error("taken jump target wrong");
	AST_JUMP_FALL: assert property (rv && da_q == OFF_NPC && jump_always && !tk |-> rdv == ep_q + STEP)
		else $error("untaken jump target wrong");
	AST_JUMP_FLAGS: assert property (rv && da_q == OFF_NSR && jump_always |-> rdv == ef_q)
		else $error("jump changed flags");
	AST_JUMP_INFO: assert property (rv && da_q == OFF_INFO && jump_always |-> rdv[6] == tk)
		else $error("jump condition wrong");
	AST_BYTE_SEL: assert property (rv && da_q == OFF_INFO && o1 >= 4'h4 |-> rdv[2] == ei_q[BW_BIT])
		else $error("byte select wrong");
	AST_KEEP_FLAGS: assert property (rv && da_q == OFF_NSR && (o1 == OP_COPY || o1 == OP_BIS) |-> rdv == ef_q)
		else $error("copy or mask-set changed flags");
	AST_STACK_DOWN: assert property (rv && da_q == OFF_NSP && ei_q[15:10] == F2_PREFIX && o2 == F2_PUSH |-> rdv == es_q - STEP)
		else $error("push stack pointer wrong");
endmodule

bind sbd_decoder sbd_decoder_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp);

// ===== verif/sbd_bus_master.sv
// Register-bus master standing in for the fetch side
`timescale 1ns/100ps
module sbd_bus_master (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [11:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	initial begin
		{hsel, haddr, htrans, hwrite, hsize, hwdata} = {1'b0, 12'hFFF, 2'h0, 1'b0, 3'h2, 32'h0};
	end
	// Entered just after a rising edge; leaves just after the data-phase edge
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		haddr <= ~a;
		hwdata <= w ? d : ~d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
		hwdata <= ~d;
	endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench: random instructions executed through the register port
`timescale 1ns/100ps
module testbench
	import sbd_pkg::*;
;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [15:0] v [8];
	logic [15:0] e [6];
	logic [15:0] mk [6];
	int          n_fail;
	int          num_checks;

	sbd_decoder dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp);
	sbd_bus_master bm (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata);

	initial hclk = 1'b0;
	always #50 hclk = ~hclk;

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic rd(input logic [11:0] a, input logic [15:0] x, input logic [15:0] m);
		logic [31:0] r;
		bm.xfer(a, 1'b0, 32'h0, r);
		num_checks++;
		if ((r & {16'hFFFF, m}) !== {16'h0000, x & m}) begin
			n_fail++;
			$display("[ERR] %0t addr %h got %h exp %h", $time, a, r, x);
		end
	endtask

	task automatic fl(input logic [15:0] r, input int w, input logic ov, input logic cy);
		e[3][SR_C] = cy;
		e[3][SR_Z] = r == 16'h0000;
		e[3][SR_N] = r[w-1];
		e[3][SR_V] = ov;
	endtask

	task automatic sum(input logic [15:0] x, input logic [15:0] y, input logic ci,
		input int w, output logic [15:0] r);
		logic [16:0] t;
		t = x + y + ci;
		r = t[15:0] & (w == 8 ? 16'h00FF : 16'hFFFF);
		fl(r, w, x[w-1] == y[w-1] && r[w-1] != x[w-1], t[w]);
	endtask

	// Reference execution of the instruction held in v
	task automatic model();
		logic [15:0] i, s, d, r, m;
		logic [7:0]  tt;
		logic [1:0]  fm;
		logic        bw, c, x, dw, sw, tk, il;
		int          w;
		int          dn;
		int          dg;
		int          dc;
		i = v[0];
		bw = i[6];
		w = bw ? 8 : 16;
		m = bw ? 16'h00FF : 16'hFFFF;
		{s, d, c, x} = {v[1] & m, v[2] & m, v[5][SR_C], v[5][SR_N] ^ v[5][SR_V]};
		{r, dw, sw, tk, il} = 20'h0;
		e = '{16'h0000, v[3] + STEP, v[4], v[5], 16'h0000, 16'h0000};
		mk = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h007F};
		if (i[15:12] >= 4'h4) begin
			fm = FMT_DUAL;
			dw = i[15:12] != OP_CMP && i[15:12] != OP_BIT;
			case (i[15:12])
				OP_COPY: r = s;
				OP_ADD, OP_SUM_WITH_CARRY_IN: sum(s, d, i[15:12] == OP_SUM_WITH_CARRY_IN && c, w, r);
				OP_SUB, OP_MINUS_WITH_CARRY, OP_CMP: sum(~s & m, d, i[15:12] == OP_MINUS_WITH_CARRY ? c : 1'b1, w, r);
				OP_DECIMAL_SUM_OP: begin
					dc = c;
					for (dn = 0; dn < w / 4; dn++) begin
						dg = s[dn*4 +: 4] + d[dn*4 +: 4] + dc;
						if (dg > 9) dg = dg + 6;
						r[dn*4 +: 4] = 4'(dg);
						dc = (dg >> 4) & 1;
					end
					fl(r, w, 1'b0, dc[0]);
					mk[3][SR_V] = 1'b0;
				end
				OP_BIC: r = ~s & d;
				OP_BIS: r = s | d;
				OP_XOR: begin r = s ^ d; fl(r, w, s[w-1] & d[w-1], r != 16'h0000); end
				default: begin r = s & d; fl(r, w, 1'b0, r != 16'h0000); end
			endcase
		end else if (i[15:10] == F2_PREFIX) begin
			fm = FMT_SINGLE;
			il = i[9:7] == F2_BAD || bw && i[9:7] != F2_RRC && i[9:7] != F2_RRA && i[9:7] != F2_PUSH;
			dw = i[9:7] < 3'h4;
			case (i[9:7])
				F2_RRC: begin r = (d >> 1) | (c ? m ^ (m >> 1) : 16'h0); fl(r, w, 1'b0, d[0]); end
				F2_RRA: begin r = (d >> 1) | (d & (m ^ (m >> 1))); fl(r, w, 1'b0, d[0]); end
				F2_BYTE_SWAP_OP: r = {d[7:0], d[15:8]};
				F2_SXT: begin r = {{8{d[7]}}, d[7:0]}; fl(r, w, 1'b0, r != 16'h0000); end
				F2_PUSH, F2_CALL: begin
					{e[2], e[4], mk[4], sw} = {v[4] - STEP, v[4] - STEP, 16'hFFFF, 1'b1};
					if (i[9:7] == F2_CALL) e[1] = v[2];
				end
				F2_INTERRUPT_RETURN_OP: {e[1], e[2], e[3]} = {v[7], v[4] + 16'h0004, v[6]};
				default: il = 1'b1;
			endcase
		end else if (i[15:13] == JMP_PREFIX) begin
			fm = FMT_JUMP;
			tt = {1'b1, x, !x, v[5][SR_N], v[5][SR_C], !v[5][SR_C], v[5][SR_Z], !v[5][SR_Z]};
			tk = tt[i[12:10]];
			if (tk) e[1] = v[3] + STEP + {{5{i[9]}}, i[9:0], 1'b0};
		end else begin
			il = 1'b1;
		end
		if (il) begin
			{fm, dw, sw, mk[4]} = {FMT_ILLEGAL, 18'h0};
			{e[1], e[2], e[3]} = {v[3], v[4], v[5]};
		end
		e[0] = r;
		if (!dw) mk[0] = 16'h0000;
		e[5] = {9'h0, tk, sw, dw, il, bw, fm};
		if (fm[1]) mk[5][2] = 1'b0;
	endtask

	initial begin
		#(100 * 40000);
		n_fail++;
		test_done();
	end

	initial begin
		logic [31:0] r;
		int          k;
		int          j;
		hresetn = 1'b0;
		void'($urandom(62));
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (k = 0; k < 17; k++) rd(12'(4 * k), 16'h0000, 16'hFFFF);
		bm.xfer(12'h040, 1'b1, 32'h0000_1234, r);
		rd(12'h040, 16'h0000, 16'hFFFF);
		for (k = 0; k < 400; k++) begin
			for (j = 1; j < 8; j++) v[j] = 16'($urandom);
			{v[3][0], v[4][0], v[5]} = {2'b00, v[5] & 16'h0107};
			case (k % 4)
				0: v[0] = {4'(4 + (k / 4) % 12), 12'($urandom)};
				1: v[0] = {F2_PREFIX, 3'(k / 4), 7'($urandom)};
				2: v[0] = {JMP_PREFIX, 3'(k / 4), k % 12 == 2 ? 10'h200 : k % 12 == 6 ? 10'h1FF : 10'($urandom)};
				default: v[0] = 16'($urandom);
			endcase
			for (j = 0; j < 8; j++) bm.xfer(12'(4 * j), 1'b1, {16'h0000, v[j]}, r);
			rd(OFF_OPA, v[1], 16'hFFFF);
			bm.xfer(OFF_CTRL, 1'b1, 32'h0000_0001, r);
			model();
			for (j = 0; j < 6; j++) rd(OFF_RESULT + 12'(4 * j), e[j], mk[j]);
			rd(OFF_CTRL, 16'h0000, 16'h0001);
		end
		test_done();
	end
endmodule
